// file: logic/pafo_pkg.sv
package pafo_pkg;

  // reset value of every registered pin and peripheral output
  localparam logic [7:0] PAFO_RST_BYTE = 8'h00;
  localparam logic PAFO_RST_BIT = 1'b0;

  // second port: serial interface pins
  localparam int PAFO_B_SEL = 0;
  localparam int PAFO_B_SCK = 1;
  localparam int PAFO_B_MOSI = 2;
  localparam int PAFO_B_MISO = 3;
  // second port: compare outputs
  localparam int PAFO_B_CMP0 = 4;
  localparam int PAFO_B_CMP1A = 5;
  localparam int PAFO_B_CMP1B = 6;
  localparam int PAFO_B_CMP7 = 7;

  // fourth port: timer and usart1 clock pins
  localparam int PAFO_D_CAP1 = 4;
  localparam int PAFO_D_UCLK1 = 5;
  localparam int PAFO_D_CNT1 = 6;
  localparam int PAFO_D_CNT2 = 7;

  // high-address mask width and the mask used in legacy mode
  localparam int PAFO_MASK_W = 3;
  localparam logic [2:0] PAFO_MASK_LEGACY = 3'h0;

  // release threshold per third-port bit, index 7 down to 0
  localparam logic [7:0][3:0] PAFO_MASK_THR = {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7};

  typedef logic [7:0] pafo_byte_t;

  // true while the mask leaves the pin claimed by the memory interface
  function automatic logic pafo_mask_claims(input logic [2:0] mask, input logic [3:0] thr);
    pafo_mask_claims = ({1'b0, mask} < thr);
  endfunction : pafo_mask_claims

endpackage : pafo_pkg

// file: logic/pafo_pin_if.sv
`timescale 1ns/1ps
// override and result bundle for one eight-pin port
interface pafo_pin_if;
  import pafo_pkg::*;
  pafo_byte_t pullup_override_en;
  pafo_byte_t pullup_override_val;
  pafo_byte_t dir_override_en;
  pafo_byte_t dir_override_val;
  pafo_byte_t value_override_en;
  pafo_byte_t value_override_val;
  pafo_byte_t input_en_override_en;
  pafo_byte_t input_en_override_val;
  pafo_byte_t port_out;
  pafo_byte_t port_dir;
  logic pullup_off;
  pafo_byte_t pin_pullup;
  pafo_byte_t pin_oe;
  pafo_byte_t pin_out;
  pafo_byte_t pin_in_en;

  modport ctrl (
    output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    output value_override_en, value_override_val, input_en_override_en, input_en_override_val,
    output port_out, port_dir, pullup_off,
    input pin_pullup, pin_oe, pin_out, pin_in_en
  );
  modport mux (
    input pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    input value_override_en, value_override_val, input_en_override_en, input_en_override_val,
    input port_out, port_dir, pullup_off,
    output pin_pullup, pin_oe, pin_out, pin_in_en
  );
endinterface : pafo_pin_if

// file: logic/pafo_port_cell.sv
`timescale 1ns/1ps
// per-pin override selection for one port
module pafo_port_cell (
  pafo_pin_if.mux p
);
  import pafo_pkg::*;

  pafo_byte_t oe_c;

  ////////////////////////////////////////////////////////////////////////////
  // each attribute takes its override when enabled, else the port setting; input enable otherwise stays on
  always_comb begin
    oe_c = (p.dir_override_en & p.dir_override_val) | (~p.dir_override_en & p.port_dir);
    p.pin_oe = oe_c;
    p.pin_out = (p.value_override_en & p.value_override_val) | (~p.value_override_en & p.port_out);
    // normal pull-up only on inputs and only while not globally disabled
    p.pin_pullup = (p.pullup_override_en & p.pullup_override_val) |
                   (~p.pullup_override_en & p.port_out & ~oe_c & {8{~p.pullup_off}});
    p.pin_in_en = (p.input_en_override_en & p.input_en_override_val) | ~p.input_en_override_en;
  end

endmodule : pafo_port_cell

// file: logic/pafo_top.sv
`timescale 1ns/1ps
module pafo_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic compat_mode,
  input wire logic global_pullup_disable,
  // second port registers and pin
  input wire pafo_pkg::pafo_byte_t portb_out,
  input wire pafo_pkg::pafo_byte_t portb_dir,
  input wire pafo_pkg::pafo_byte_t portb_pin_in,
  output logic [7:0] portb_pin_out,
  output logic [7:0] portb_pin_oe,
  output logic [7:0] portb_pullup,
  output logic [7:0] portb_in_en,
  // third port registers and pin
  input wire pafo_pkg::pafo_byte_t portc_out,
  input wire pafo_pkg::pafo_byte_t portc_dir,
  output logic [7:0] portc_pin_out,
  output logic [7:0] portc_pin_oe,
  output logic [7:0] portc_pullup,
  output logic [7:0] portc_in_en,
  // fourth port registers and pin
  input wire pafo_pkg::pafo_byte_t portd_out,
  input wire pafo_pkg::pafo_byte_t portd_dir,
  input wire pafo_pkg::pafo_byte_t portd_pin_in,
  output logic [7:0] portd_pin_out,
  output logic [7:0] portd_pin_oe,
  output logic [7:0] portd_pullup,
  output logic [7:0] portd_in_en,
  // serial peripheral interface
  input wire logic serial_if_enable,
  input wire logic serial_if_master_select,
  input wire logic spi_master_tx,
  input wire logic spi_slave_tx,
  input wire logic spi_clock_out,
  output logic spi_master_rx,
  output logic spi_slave_rx,
  output logic spi_clock_in,
  output logic spi_slave_select_n,
  output logic spi_slave_active,
  // compare outputs
  input wire logic compare0_en,
  input wire logic compare0_out,
  input wire logic compare1a_en,
  input wire logic compare1a_out,
  input wire logic compare1b_en,
  input wire logic compare1b_out,
  input wire logic compare1c_en,
  input wire logic compare1c_out,
  input wire logic compare2_en,
  input wire logic compare2_out,
  // external memory high address
  input wire logic ext_mem_enable,
  input wire logic [2:0] high_address_mask,
  input wire pafo_pkg::pafo_byte_t high_addr,
  // usart1 clock and timer inputs
  input wire logic usart1_sync_mode,
  input wire logic usart1_clock_out,
  output logic usart1_ext_clock_pin,
  output logic timer1_capture_pin,
  output logic counter1_clock_pin,
  output logic counter2_clock_pin
);
  import pafo_pkg::*;

  pafo_pin_if pb ();
  pafo_pin_if pc ();
  pafo_pin_if pd ();

  logic spi_slave_mode;
  logic spi_master_mode;
  logic [2:0] mask_eff;
  pafo_byte_t mem_claim;
  logic b7_en;
  logic b7_val;
  logic xck_used;

  pafo_byte_t portb_pin_out_q, portb_pin_out_d;
  pafo_byte_t portb_pin_oe_q, portb_pin_oe_d;
  pafo_byte_t portb_pullup_q, portb_pullup_d;
  pafo_byte_t portb_in_en_q, portb_in_en_d;
  pafo_byte_t portc_pin_out_q, portc_pin_out_d;
  pafo_byte_t portc_pin_oe_q, portc_pin_oe_d;
  pafo_byte_t portc_pullup_q, portc_pullup_d;
  pafo_byte_t portc_in_en_q, portc_in_en_d;
  pafo_byte_t portd_pin_out_q, portd_pin_out_d;
  pafo_byte_t portd_pin_oe_q, portd_pin_oe_d;
  pafo_byte_t portd_pullup_q, portd_pullup_d;
  pafo_byte_t portd_in_en_q, portd_in_en_d;
  logic spi_master_rx_q, spi_master_rx_d;
  logic spi_slave_rx_q, spi_slave_rx_d;
  logic spi_clock_in_q, spi_clock_in_d;
  logic spi_slave_select_n_q, spi_slave_select_n_d;
  logic spi_slave_active_q, spi_slave_active_d;
  logic usart1_ext_clock_pin_q, usart1_ext_clock_pin_d;
  logic timer1_capture_pin_q, timer1_capture_pin_d;
  logic counter1_clock_pin_q, counter1_clock_pin_d;
  logic counter2_clock_pin_q, counter2_clock_pin_d;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode shared by the port logic
  always_comb begin
    spi_slave_mode = serial_if_enable & ~serial_if_master_select;
    spi_master_mode = serial_if_enable & serial_if_master_select;
    mask_eff = compat_mode ? PAFO_MASK_LEGACY : high_address_mask;
    // timer 2 wins if both compare units drive bit 7; the pin cannot show both
    b7_en = compare2_en | (~compat_mode & compare1c_en);
    b7_val = compare2_en ? compare2_out : compare1c_out;
    xck_used = usart1_sync_mode & ~compat_mode;
    for (int i = 0; i < 8; i++) begin
      mem_claim[i] = ext_mem_enable & pafo_mask_claims(mask_eff, PAFO_MASK_THR[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second port overrides: serial interface low nibble, compares high nibble
  always_comb begin
    pb.port_out = portb_out;
    pb.port_dir = portb_dir;
    pb.pullup_off = global_pullup_disable;
    pb.dir_override_val = PAFO_RST_BYTE; // any override forces input
    pb.pullup_override_val = portb_out & {8{~global_pullup_disable}};
    pb.input_en_override_en = PAFO_RST_BYTE; // never overridden
    pb.input_en_override_val = PAFO_RST_BYTE;
    pb.pullup_override_en = PAFO_RST_BYTE;
    pb.dir_override_en = PAFO_RST_BYTE;
    pb.value_override_en = PAFO_RST_BYTE;
    pb.value_override_val = PAFO_RST_BYTE;
    // slave forces select, clock and data-in to input
    pb.pullup_override_en[PAFO_B_SEL] = spi_slave_mode;
    pb.dir_override_en[PAFO_B_SEL] = spi_slave_mode;
    pb.pullup_override_en[PAFO_B_SCK] = spi_slave_mode;
    pb.dir_override_en[PAFO_B_SCK] = spi_slave_mode;
    pb.pullup_override_en[PAFO_B_MOSI] = spi_slave_mode;
    pb.dir_override_en[PAFO_B_MOSI] = spi_slave_mode;
    // master forces data-in pin to input
    pb.pullup_override_en[PAFO_B_MISO] = spi_master_mode;
    pb.dir_override_en[PAFO_B_MISO] = spi_master_mode;
    // output values; direction still comes from the port bit
    pb.value_override_en[PAFO_B_MISO] = spi_slave_mode;
    pb.value_override_val[PAFO_B_MISO] = spi_slave_tx;
    pb.value_override_en[PAFO_B_MOSI] = spi_master_mode;
    pb.value_override_val[PAFO_B_MOSI] = spi_master_tx;
    pb.value_override_en[PAFO_B_SCK] = spi_master_mode;
    pb.value_override_val[PAFO_B_SCK] = spi_clock_out;
    // compare waveforms; pin shows them only once software sets direction
    pb.value_override_en[PAFO_B_CMP0] = compare0_en;
    pb.value_override_val[PAFO_B_CMP0] = compare0_out;
    pb.value_override_en[PAFO_B_CMP1A] = compare1a_en;
    pb.value_override_val[PAFO_B_CMP1A] = compare1a_out;
    pb.value_override_en[PAFO_B_CMP1B] = compare1b_en;
    pb.value_override_val[PAFO_B_CMP1B] = compare1b_out;
    pb.value_override_en[PAFO_B_CMP7] = b7_en;
    pb.value_override_val[PAFO_B_CMP7] = b7_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // third port: high address byte, or output-only in legacy mode
  always_comb begin
    pc.port_out = portc_out;
    pc.port_dir = portc_dir;
    pc.pullup_off = global_pullup_disable;
    pc.input_en_override_en = PAFO_RST_BYTE;
    pc.input_en_override_val = PAFO_RST_BYTE;
    pc.pullup_override_val = PAFO_RST_BYTE; // pull-up off when claimed
    pc.dir_override_val = ~PAFO_RST_BYTE; // claimed pins drive
    pc.value_override_en = mem_claim;
    pc.value_override_val = high_addr; // bit i carries address bit 8+i
    // legacy mode pins stay outputs whether or not memory claims them
    pc.pullup_override_en = compat_mode ? ~PAFO_RST_BYTE : mem_claim;
    pc.dir_override_en = compat_mode ? ~PAFO_RST_BYTE : mem_claim;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fourth port: only the usart1 clock drives a value
  always_comb begin
    pd.port_out = portd_out;
    pd.port_dir = portd_dir;
    pd.pullup_off = global_pullup_disable;
    pd.pullup_override_en = PAFO_RST_BYTE;
    pd.pullup_override_val = PAFO_RST_BYTE;
    pd.dir_override_en = PAFO_RST_BYTE; // clock direction from its bit
    pd.dir_override_val = PAFO_RST_BYTE;
    pd.input_en_override_en = PAFO_RST_BYTE;
    pd.input_en_override_val = PAFO_RST_BYTE;
    pd.value_override_en = PAFO_RST_BYTE;
    pd.value_override_val = PAFO_RST_BYTE;
    pd.value_override_en[PAFO_D_UCLK1] = xck_used;
    pd.value_override_val[PAFO_D_UCLK1] = usart1_clock_out;
  end

  pafo_port_cell u_cell_b (
    .p(pb.mux)
  );

  pafo_port_cell u_cell_c (
    .p(pc.mux)
  );

  pafo_port_cell u_cell_d (
    .p(pd.mux)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next values of pin drives and peripheral inputs
  always_comb begin
    portb_pin_out_d = pb.pin_out;
    portb_pin_oe_d = pb.pin_oe;
    portb_pullup_d = pb.pin_pullup;
    portb_in_en_d = pb.pin_in_en;
    portc_pin_out_d = pc.pin_out;
    portc_pin_oe_d = pc.pin_oe;
    portc_pullup_d = pc.pin_pullup;
    portc_in_en_d = pc.pin_in_en;
    portd_pin_out_d = pd.pin_out;
    portd_pin_oe_d = pd.pin_oe;
    portd_pullup_d = pd.pin_pullup;
    portd_in_en_d = pd.pin_in_en;
    spi_master_rx_d = portb_pin_in[PAFO_B_MISO];
    spi_slave_rx_d = portb_pin_in[PAFO_B_MOSI];
    spi_clock_in_d = portb_pin_in[PAFO_B_SCK];
    spi_slave_select_n_d = portb_pin_in[PAFO_B_SEL];
    spi_slave_active_d = spi_slave_mode & ~portb_pin_in[PAFO_B_SEL];
    // clock input held low outside synchronous mode so no stray edges reach usart1
    usart1_ext_clock_pin_d = xck_used & portd_pin_in[PAFO_D_UCLK1];
    timer1_capture_pin_d = portd_pin_in[PAFO_D_CAP1];
    counter1_clock_pin_d = portd_pin_in[PAFO_D_CNT1];
    counter2_clock_pin_d = portd_pin_in[PAFO_D_CNT2];
  end

  // registers only; one cycle of latency traded for glitch-free pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portb_pin_out_q <= PAFO_RST_BYTE;
      portb_pin_oe_q <= PAFO_RST_BYTE;
      portb_pullup_q <= PAFO_RST_BYTE;
      portb_in_en_q <= PAFO_RST_BYTE;
      portc_pin_out_q <= PAFO_RST_BYTE;
      portc_pin_oe_q <= PAFO_RST_BYTE;
      portc_pullup_q <= PAFO_RST_BYTE;
      portc_in_en_q <= PAFO_RST_BYTE;
      portd_pin_out_q <= PAFO_RST_BYTE;
      portd_pin_oe_q <= PAFO_RST_BYTE;
      portd_pullup_q <= PAFO_RST_BYTE;
      portd_in_en_q <= PAFO_RST_BYTE;
      spi_master_rx_q <= PAFO_RST_BIT;
      spi_slave_rx_q <= PAFO_RST_BIT;
      spi_clock_in_q <= PAFO_RST_BIT;
      spi_slave_select_n_q <= PAFO_RST_BIT;
      spi_slave_active_q <= PAFO_RST_BIT;
      usart1_ext_clock_pin_q <= PAFO_RST_BIT;
      timer1_capture_pin_q <= PAFO_RST_BIT;
      counter1_clock_pin_q <= PAFO_RST_BIT;
      counter2_clock_pin_q <= PAFO_RST_BIT;
    end else begin
      portb_pin_out_q <= portb_pin_out_d;
      portb_pin_oe_q <= portb_pin_oe_d;
      portb_pullup_q <= portb_pullup_d;
      portb_in_en_q <= portb_in_en_d;
      portc_pin_out_q <= portc_pin_out_d;
      portc_pin_oe_q <= portc_pin_oe_d;
      portc_pullup_q <= portc_pullup_d;
      portc_in_en_q <= portc_in_en_d;
      portd_pin_out_q <= portd_pin_out_d;
      portd_pin_oe_q <= portd_pin_oe_d;
      portd_pullup_q <= portd_pullup_d;
      portd_in_en_q <= portd_in_en_d;
      spi_master_rx_q <= spi_master_rx_d;
      spi_slave_rx_q <= spi_slave_rx_d;
      spi_clock_in_q <= spi_clock_in_d;
      spi_slave_select_n_q <= spi_slave_select_n_d;
      spi_slave_active_q <= spi_slave_active_d;
      usart1_ext_clock_pin_q <= usart1_ext_clock_pin_d;
      timer1_capture_pin_q <= timer1_capture_pin_d;
      counter1_clock_pin_q <= counter1_clock_pin_d;
      counter2_clock_pin_q <= counter2_clock_pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign portb_pin_out = portb_pin_out_q;
  assign portb_pin_oe = portb_pin_oe_q;
  assign portb_pullup = portb_pullup_q;
  assign portb_in_en = portb_in_en_q;
  assign portc_pin_out = portc_pin_out_q;
  assign portc_pin_oe = portc_pin_oe_q;
  assign portc_pullup = portc_pullup_q;
  assign portc_in_en = portc_in_en_q;
  assign portd_pin_out = portd_pin_out_q;
  assign portd_pin_oe = portd_pin_oe_q;
  assign portd_pullup = portd_pullup_q;
  assign portd_in_en = portd_in_en_q;
  assign spi_master_rx = spi_master_rx_q;
  assign spi_slave_rx = spi_slave_rx_q;
  assign spi_clock_in = spi_clock_in_q;
  assign spi_slave_select_n = spi_slave_select_n_q;
  assign spi_slave_active = spi_slave_active_q;
  assign usart1_ext_clock_pin = usart1_ext_clock_pin_q;
  assign timer1_capture_pin = timer1_capture_pin_q;
  assign counter1_clock_pin = counter1_clock_pin_q;
  assign counter2_clock_pin = counter2_clock_pin_q;

endmodule : pafo_top

// file: sim/pafo_pin_model.sv
`timescale 1ns/1ps
// far side of the pads: peripherals, memory and pull-up resistors
module pafo_pin_model (
  input wire logic clk,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] float_q = 8'h5A;
  ////////////////////////////////////////////////////////////
  // a floating pad wanders each cycle so a stale level never passes for a driven one
  always @(posedge clk) float_q <= ~float_q;
  // the far side drives only a released pad, e.g. an outside master pulling select low
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pull_en | float_q));
endmodule : pafo_pin_model

// file: sim/pafo_top_chk.sv
`timescale 1ns/1ps
// pin override checker: every pin follows its cause one cycle later
module pafo_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic compat_mode,
  input wire logic global_pullup_disable,
  input wire pafo_pkg::pafo_byte_t portb_out,
  input wire pafo_pkg::pafo_byte_t portb_dir,
  input wire pafo_pkg::pafo_byte_t portb_pin_in,
  input wire logic [7:0] portb_pin_out,
  input wire logic [7:0] portb_pin_oe,
  input wire logic [7:0] portb_pullup,
  input wire pafo_pkg::pafo_byte_t portc_out,
  input wire logic [7:0] portc_pin_out,
  input wire logic [7:0] portc_pin_oe,
  input wire logic [7:0] portc_pullup,
  input wire pafo_pkg::pafo_byte_t portd_dir,
  input wire pafo_pkg::pafo_byte_t portd_pin_in,
  input wire logic [7:0] portd_pin_oe,
  input wire logic serial_if_enable,
  input wire logic serial_if_master_select,
  input wire logic spi_master_tx,
  input wire logic spi_slave_tx,
  input wire logic spi_clock_out,
  input wire logic spi_slave_active,
  input wire logic compare1a_en,
  input wire logic compare1a_out,
  input wire logic compare2_en,
  input wire logic ext_mem_enable,
  input wire logic [2:0] high_address_mask,
  input wire pafo_pkg::pafo_byte_t high_addr,
  input wire logic usart1_sync_mode,
  input wire logic usart1_ext_clock_pin
);
  import pafo_pkg::*;
  logic sel_c;
  logic uclk_c;
  // select and usart clock as the pins should present them
  assign sel_c = serial_if_enable & ~serial_if_master_select & ~portb_pin_in[0];
  assign uclk_c = portd_pin_in[5] & usart1_sync_mode & ~compat_mode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  sequence s_slave;
    serial_if_enable && !serial_if_master_select;
  endsequence
  sequence s_master;
    serial_if_enable && serial_if_master_select;
  endsequence
  property p_slave_pins;
    s_slave |=> portb_pin_oe[2:0] == 3'h0 && portb_pin_out[3] == $past(spi_slave_tx)
      && portb_pullup[2:0] == ($past(portb_out[2:0]) & {3{!$past(global_pullup_disable)}});
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave pins not forced to input");
  property p_master_path;
    s_master |=> !portb_pin_oe[3] && portb_pin_oe[2:0] == $past(portb_dir[2:0])
      && portb_pin_out[2:1] == {$past(spi_master_tx), $past(spi_clock_out)};
  endproperty
  a_master_path: assert property (p_master_path) else $error("master pin routing wrong");
  property p_slave_active;
    1'b1 |=> spi_slave_active == $past(sel_c);
  endproperty
  a_slave_active: assert property (p_slave_active) else $error("slave active flag wrong");
  property p_compare_val;
    compare1a_en |=> portb_pin_out[5] == $past(compare1a_out);
  endproperty
  a_compare_val: assert property (p_compare_val) else $error("compare waveform not on pin");
  property p_legacy_b7;
    compat_mode && !compare2_en |=> portb_pin_out[7] == $past(portb_out[7]);
  endproperty
  a_legacy_b7: assert property (p_legacy_b7) else $error("legacy bit 7 not from port");
  property p_addr_claim;
    ext_mem_enable && (compat_mode || high_address_mask == 3'h0)
      |=> portc_pin_oe == 8'hFF && portc_pullup == 8'h00 && portc_pin_out == $past(high_addr);
  endproperty
  a_addr_claim: assert property (p_addr_claim) else $error("high address not driven");
  property p_mask_release;
    ext_mem_enable && !compat_mode && high_address_mask == 3'h4 |=> portc_pin_oe[3:0] == 4'hF
      && portc_pin_out[7:4] == $past(portc_out[7:4]) && portc_pin_out[3:0] == $past(high_addr[3:0]);
  endproperty
  a_mask_release: assert property (p_mask_release) else $error("mask release boundary wrong");
  property p_usart_clk;
    1'b1 |=> usart1_ext_clock_pin == $past(uclk_c) && portd_pin_oe[5] == $past(portd_dir[5]);
  endproperty
  a_usart_clk: assert property (p_usart_clk) else $error("usart clock pin wrong");
endmodule : pafo_top_chk

// file: sim/pafo_top_tb.sv
`timescale 1ns/1ps
module pafo_top_tb;
  import pafo_pkg::*;
  typedef struct packed {
    logic [7:0] b_out, b_oe, b_pu, c_out, c_oe, c_pu, d_out, d_oe, d_pu, in_en;
    logic [8:0] misc;
  } pafo_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic compat_mode, global_pullup_disable, serial_if_enable, serial_if_master_select, spi_master_tx, spi_slave_tx;
  logic spi_clock_out, ext_mem_enable, usart1_sync_mode, usart1_clock_out, compare0_en, compare0_out;
  logic compare1a_en, compare1a_out, compare1b_en, compare1b_out, compare1c_en, compare1c_out, compare2_en, compare2_out;
  logic [2:0] high_address_mask;
  pafo_byte_t portb_out, portb_dir, portb_pin_in, portc_out, portc_dir, portd_out, portd_dir, portd_pin_in, high_addr;
  pafo_byte_t extb_en, extb_val, extd_en, extd_val;
  logic [7:0] portb_pin_out, portb_pin_oe, portb_pullup, portb_in_en, portc_pin_out, portc_pin_oe, portc_pullup;
  logic [7:0] portc_in_en, portd_pin_out, portd_pin_oe, portd_pullup, portd_in_en;
  logic spi_master_rx, spi_slave_rx, spi_clock_in, spi_slave_select_n, spi_slave_active;
  logic usart1_ext_clock_pin, timer1_capture_pin, counter1_clock_pin, counter2_clock_pin;
  logic [31:0] seed;
  pafo_exp_t e_q;
  int errors, checked;
  pafo_top pafo_top_inst (.*);
  pafo_pin_model b_side_inst (.clk(clk), .pin_oe(portb_pin_oe), .pin_out(portb_pin_out), .pull_en(portb_pullup),
    .ext_en(extb_en), .ext_val(extb_val), .pin_in(portb_pin_in));
  pafo_pin_model d_side_inst (.clk(clk), .pin_oe(portd_pin_oe), .pin_out(portd_pin_out), .pull_en(portd_pullup),
    .ext_en(extd_en), .ext_val(extd_val), .pin_in(portd_pin_in));
  // 100 ns clock
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // every input, far-side drivers included, gets fresh bits
  task automatic shuffle();
    logic [127:0] r;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r = {r[95:0], seed};
    end
    {compat_mode, global_pullup_disable, portb_out, portb_dir, portc_out, portc_dir, portd_out, portd_dir,
      serial_if_enable, serial_if_master_select, spi_master_tx, spi_slave_tx, spi_clock_out, compare0_en,
      compare0_out, compare1a_en, compare1a_out, compare1b_en, compare1b_out, compare1c_en, compare1c_out,
      compare2_en, compare2_out, ext_mem_enable, high_address_mask, high_addr, usart1_sync_mode,
      usart1_clock_out, extb_en, extb_val, extd_en, extd_val} = r[110:0];
  endtask : shuffle
  // reference pin mux from the inputs seen at one edge
  function automatic pafo_exp_t ref_model();
    pafo_exp_t e;
    logic slv, mas, clm;
    logic [2:0] m;
    slv = serial_if_enable & ~serial_if_master_select;
    mas = serial_if_enable & serial_if_master_select;
    m = compat_mode ? 3'h0 : high_address_mask;
    e.b_oe = portb_dir & ~{4'h0, mas, slv, slv, slv};
    e.b_out = {compare2_en ? compare2_out : (compare1c_en & ~compat_mode) ? compare1c_out : portb_out[7],
      compare1b_en ? compare1b_out : portb_out[6], compare1a_en ? compare1a_out : portb_out[5],
      compare0_en ? compare0_out : portb_out[4], slv ? spi_slave_tx : portb_out[3],
      mas ? {spi_master_tx, spi_clock_out} : portb_out[2:1], portb_out[0]};
    e.b_pu = portb_out & ~e.b_oe & {8{~global_pullup_disable}};
    for (int i = 0; i < 8; i++) begin
      clm = ext_mem_enable & ({1'b0, m} < ((i == 0) ? 4'h7 : 4'(8 - i)));
      e.c_oe[i] = clm | compat_mode | portc_dir[i];
      e.c_out[i] = clm ? high_addr[i] : portc_out[i];
    end
    e.c_pu = portc_out & ~e.c_oe & {8{~global_pullup_disable}};
    e.d_oe = portd_dir;
    e.d_out = portd_out;
    e.d_out[5] = (usart1_sync_mode & ~compat_mode) ? usart1_clock_out : portd_out[5];
    e.d_pu = portd_out & ~portd_dir & {8{~global_pullup_disable}};
    e.in_en = 8'hFF;
    e.misc = {portb_pin_in[3:0], slv & ~portb_pin_in[0], portd_pin_in[5] & usart1_sync_mode & ~compat_mode,
      portd_pin_in[4], portd_pin_in[6], portd_pin_in[7]};
    return e;
  endfunction : ref_model
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk9
  task automatic tally_and_finish();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////
  // expectation lags one edge like the design; zero while in reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) e_q <= '0;
    else e_q <= ref_model();
  end
  // outputs are settled at the falling edge
  always @(negedge clk) begin
    chk8(portb_pin_out, e_q.b_out);
    chk8(portb_pin_oe, e_q.b_oe);
    chk8(portb_pullup, e_q.b_pu);
    chk8(portc_pin_out, e_q.c_out);
    chk8(portc_pin_oe, e_q.c_oe);
    chk8(portc_pullup, e_q.c_pu);
    chk8(portd_pin_out, e_q.d_out);
    chk8(portd_pin_oe, e_q.d_oe);
    chk8(portd_pullup, e_q.d_pu);
    chk8(portb_in_en, e_q.in_en);
    chk8(portc_in_en, e_q.in_en);
    chk8(portd_in_en, e_q.in_en);
    chk9({spi_master_rx, spi_slave_rx, spi_clock_in, spi_slave_select_n, spi_slave_active, usart1_ext_clock_pin,
      timer1_capture_pin, counter1_clock_pin, counter2_clock_pin}, e_q.misc);
  end
  // main sequence: random traffic, a directed sweep, then a mid-run reset
  initial begin
    seed = 32'h52A8;
    errors = 0;
    checked = 0;
    shuffle();
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (300) begin
      @(negedge clk);
      shuffle();
    end
    // every mask value in both modes, slave and master alternating, select high and low
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      shuffle();
      {ext_mem_enable, high_address_mask, compat_mode} = {1'b1, k[2:0], k[3]};
      {serial_if_enable, serial_if_master_select, portb_dir} = {1'b1, k[0], 8'hFF};
      {extb_en[0], extb_val[0]} = {1'b1, k[1]};
      {compare2_en, compare1c_en, usart1_sync_mode, portd_dir[5]} = {k[2], 1'b1, 1'b1, k[1]};
    end
    // reset dropped between edges to prove it needs no clock
    @(negedge clk);
    #20 rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (200) begin
      @(negedge clk);
      shuffle();
    end
    @(negedge clk);
    tally_and_finish();
  end
  // about 520 cycles are expected; nearly four times that means a hang
  initial begin
    #(2000 * 100);
    errors++;
    tally_and_finish();
  end
endmodule : pafo_top_tb
bind pafo_top pafo_top_chk pafo_top_chk_inst (.*);
